//--- tprp_params.svh
// Constants for the tape reader/punch controller.
// Assumes inclusion by the controller module only.
`ifndef TPRP_PARAMS_SVH
`define TPRP_PARAMS_SVH
// Status bit positions; bit 8 of the byte is index 7 here.
`define TPRP_ST_OVERFLOW 7
`define TPRP_ST_STOPPED 4
`define TPRP_ST_BUSY 3
`define TPRP_ST_EXAMINE 2
`define TPRP_ST_UNAVAIL 0
// Command bit positions; bit 8 of the byte is index 7 here.
`define TPRP_CMD_DISABLE 7
`define TPRP_CMD_ENABLE 6
`define TPRP_CMD_STOP 5
`define TPRP_CMD_RUN 4
`define TPRP_CMD_STEP 3
`define TPRP_CMD_SLEW 2
`define TPRP_CMD_PUNCH 1
`define TPRP_CMD_READER 0
// Default device addresses.
`define TPRP_ADDR_READER_ONLY 8'h03
`define TPRP_ADDR_COMBINED 8'h13
// Out-of-tape timeout.
`define TPRP_FEED_TIMEOUT_US 10000
`define TPRP_CLK_MHZ 100
`define TPRP_FEED_TIMEOUT_CYC (`TPRP_FEED_TIMEOUT_US * `TPRP_CLK_MHZ)
`endif

//--- tprp_pkg.sv
// Types for the tape reader/punch controller.
// Assumes the parameter header is included alongside.
package tprp_pkg;
    typedef enum logic [1:0] {
        TPRP_IRQ_DISARMED,
        TPRP_IRQ_DISABLED,
        TPRP_IRQ_ENABLED
    } tprp_irq_mode_t;
    typedef enum logic [2:0] {
        TPRP_OP_NONE,
        TPRP_OP_COMMAND,
        TPRP_OP_STATUS,
        TPRP_OP_WRITE,
        TPRP_OP_READ,
        TPRP_OP_ACK
    } tprp_op_t;
endpackage : tprp_pkg

//--- tprp_ctrl.sv
// Paper tape reader/punch controller on a byte-wide processor I/O port.
// Assumes one-cycle op strobes from the processor side and synchronous
// reader/punch condition inputs.
//
// Functional notes
// - Initialize on reset only when reader ready.
// - Init disarms, sets stopped and examine flags.
// - Init: disarmed, stopped, step motion, reader.
// - Init loads busy from reader condition.
// - Mode change clears pending, then rechecks busy.
// - Status bits overflow, stopped, busy, examine, unavailable.
// - Command bits: disable,enable,stop,run,step,slew,punch,reader.
// - Disable plus enable disarms; nothing queued.
// - Disable alone queues but blocks requests.
// - Enable alone lets interrupts reach processor.
// - Overflow when new character overwrites untaken.
// - Overflow cleared on init, mode change, start.
// - Punch mode holds overflow, stopped, examine clear.
// - Reader unavailable: power, load, feed timeout.
// - Punch unavailable: power, voltage, load, chad.
// - Stopped flag set on halt, cleared moving.
// - Reader busy: buffer empty, load, unstable power.
// - Punch busy during punch cycle.
// - Examine is overflow OR stopped.
// - Step motion: each read advances one character.
// - Slew: run starts, stop halts tape.
// - Command, status, write, read transfers defined.
// - Acknowledge returns address and status.
// - Address 03 reader-only, 13 combined, parameter.
// - Busy to not-busy raises interrupt.
// - Unavailable rising edge raises interrupt.
// - Acknowledge and disarm clear pending interrupt.
`timescale 1ns/100ps
`include "tprp_params.svh"

module tprp_ctrl #(
    parameter bit PUNCH_FITTED = 1'b1,
    parameter logic [7:0] DEV_ADDR = PUNCH_FITTED ?
        `TPRP_ADDR_COMBINED : `TPRP_ADDR_READER_ONLY,
    parameter int FEED_TIMEOUT = `TPRP_FEED_TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire tprp_pkg::tprp_op_t op,
    input wire logic [7:0] op_data,
    output logic [7:0] op_rdata,
    output logic [7:0] ack_addr,
    output logic irq_req,
    input wire logic reader_power_ok,
    input wire logic reader_run,
    input wire logic reader_char_strobe,
    input wire logic [7:0] reader_char,
    input wire logic reader_feed_hole,
    output logic reader_drive,
    input wire logic punch_power_ok,
    input wire logic punch_volts_ok,
    input wire logic punch_run,
    input wire logic punch_chad_full,
    input wire logic punch_ready,
    output logic punch_strobe,
    output logic [7:0] punch_char
);
    import tprp_pkg::*;

    // A data-write only reaches the punch while the punch is selected.
    function automatic logic punch_take(tprp_op_t o, logic sel);
        return (o == TPRP_OP_WRITE) && sel;
    endfunction : punch_take

    // Maps the two interrupt bits of a command onto the armed state.
    // Both bits together disarm, and neither bit leaves the state alone.
    function automatic tprp_irq_mode_t irq_decode(logic dis, logic ena,
                                                  tprp_irq_mode_t cur);
        tprp_irq_mode_t m;
        m = cur;
        if (dis && ena) begin
            m = TPRP_IRQ_DISARMED;
        end else if (dis) begin
            m = TPRP_IRQ_DISABLED;
        end else if (ena) begin
            m = TPRP_IRQ_ENABLED;
        end
        return m;
    endfunction : irq_decode

    // Packs the status byte. Reader-only flags read clear in punch mode,
    // even in the first cycle after a mode change before they settle.
    function automatic logic [7:0] status_pack(logic ovf, logic stp,
                                               logic unit_busy_flag, logic exm,
                                               logic unv, logic pun);
        logic [7:0] s;
        s = 8'h00;
        s[`TPRP_ST_OVERFLOW] = ovf && !pun;
        s[`TPRP_ST_STOPPED] = stp && !pun;
        s[`TPRP_ST_BUSY] = unit_busy_flag;
        s[`TPRP_ST_EXAMINE] = exm && !pun;
        s[`TPRP_ST_UNAVAIL] = unv;
        return s;
    endfunction : status_pack

    // ======================================================
    // Command state
    // ======================================================
    tprp_irq_mode_t irq_mode_r;
    logic run_r;
    logic slew_r;
    logic punch_sel_r;
    logic pending_r;
    logic overflow_r;
    logic stopped_r;
    logic buf_full_r;
    logic [7:0] buf_r;
    logic step_go_r;
    logic busy_prev_r;
    logic unavail_prev_r;
    logic [31:0] feed_cnt_r;
    logic feed_timeout_r;

    logic init;
    logic cmd;
    logic mode_change;
    logic new_punch;
    logic busy;
    logic unavail;
    logic examine;
    logic [7:0] status;

    // Initialization needs the reader powered and in run. A reset request
    // with the reader down leaves every register untouched, so the state
    // that software set up survives a stray initialize.
    assign init = rst && reader_power_ok && reader_run;
    assign cmd = (op == TPRP_OP_COMMAND);
    // A mode change needs exactly one unit bit. A punch request on a
    // reader-only build is ignored so that the reader stays selected.
    assign new_punch = op_data[`TPRP_CMD_PUNCH] && PUNCH_FITTED;
    assign mode_change = cmd &&
        (op_data[`TPRP_CMD_PUNCH] ^ op_data[`TPRP_CMD_READER]) &&
        (new_punch != punch_sel_r);

    // The interrupt mode only moves on init or a command; a command without either
    // interrupt bit keeps the mode that software chose earlier.
    always_ff @(posedge clk) begin
        if (init) begin
            irq_mode_r <= TPRP_IRQ_DISARMED;
        end else if (cmd) begin
            irq_mode_r <= irq_decode(op_data[`TPRP_CMD_DISABLE],
                                     op_data[`TPRP_CMD_ENABLE], irq_mode_r);
        end
    end

    // Stop wins over run when both are set, so a confused command byte
    // halts the tape rather than leaving it moving unattended.
    // Slew wins over step in the same way.

    always_ff @(posedge clk) begin
        if (init) begin
            run_r <= 1'b0;
            slew_r <= 1'b0;
            punch_sel_r <= 1'b0;
        end else if (cmd) begin
            if (op_data[`TPRP_CMD_STOP]) begin
                run_r <= 1'b0;
            end else if (op_data[`TPRP_CMD_RUN]) begin
                run_r <= 1'b1;
            end
            if (op_data[`TPRP_CMD_SLEW]) begin
                slew_r <= 1'b1;
            end else if (op_data[`TPRP_CMD_STEP]) begin
                slew_r <= 1'b0;
            end
            if (mode_change) begin
                punch_sel_r <= new_punch;
            end
        end
    end

    // ======================================================
    // Reader motion and character buffer
    // ======================================================
    logic read_op;
    logic moving;
    assign read_op = (op == TPRP_OP_READ) && !punch_sel_r;
    assign moving = !punch_sel_r && run_r && (slew_r || step_go_r);
    assign reader_drive = moving;

    // In step motion a read starts the tape and the next sensed character
    // stops it. Leaving run, entering slew or selecting the punch drops
    // a half-done step so that it cannot resume later on its own.
    always_ff @(posedge clk) begin
        if (init || !run_r || slew_r || punch_sel_r) begin
            step_go_r <= 1'b0;
        end else if (read_op) begin
            step_go_r <= 1'b1;
        end else if (reader_char_strobe) begin
            step_go_r <= 1'b0;
        end
    end

    // A character arriving in the same cycle as a read refills the buffer;
    // the read still returns the older character, so nothing is lost.
    // Characters are only taken while the tape is driven.
    always_ff @(posedge clk) begin
        if (init) begin
            buf_full_r <= 1'b0;
            buf_r <= 8'h00;
        end else if (reader_char_strobe && moving) begin
            buf_full_r <= 1'b1;
            buf_r <= reader_char;
        end else if (read_op) begin
            buf_full_r <= 1'b0;
        end
    end

    // Overflow is only set by a character landing on an untaken one, which
    // needs continuous motion. Clearing on a run command from a stopped
    // reader gives software a clean start after recovering from overflow.
    always_ff @(posedge clk) begin
        if (init || mode_change || punch_sel_r) begin
            overflow_r <= 1'b0;
        end else if (cmd && op_data[`TPRP_CMD_RUN] &&
                     !op_data[`TPRP_CMD_STOP] && !run_r) begin
            overflow_r <= 1'b0;
        end else if (reader_char_strobe && moving && buf_full_r &&
                     !read_op) begin
            overflow_r <= 1'b1;
        end
    end

    // The stopped flag follows the drive request one cycle late, so it
    // reads set whenever the reader is selected and its tape is at rest on a character.
    always_ff @(posedge clk) begin
        if (init) begin
            stopped_r <= 1'b1;
        end else if (punch_sel_r) begin
            stopped_r <= 1'b0;
        end else if (moving) begin
            stopped_r <= 1'b0;
        end else begin
            stopped_r <= 1'b1;
        end
    end

    // The feed watchdog only runs while the tape is driven. A timeout is
    // held while the tape is at rest so that software can still see the
    // out-of-tape condition, and it clears at the next sensed feed hole.
    always_ff @(posedge clk) begin
        if (init || !moving || reader_feed_hole) begin
            feed_cnt_r <= '0;
            feed_timeout_r <= init ? 1'b0 : (feed_timeout_r && !moving);
        end else if (feed_cnt_r >= 32'(FEED_TIMEOUT - 1)) begin
            feed_timeout_r <= 1'b1;
        end else begin
            feed_cnt_r <= feed_cnt_r + 32'd1;
        end
    end

    // ======================================================
    // Punch path
    // ======================================================
    // The punch strobe lasts one cycle; the character stays on its lines
    // until the next write so that a slow punch can latch it late.
    always_ff @(posedge clk) begin
        if (init) begin
            punch_strobe <= 1'b0;
            punch_char <= 8'h00;
        end else begin
            punch_strobe <= punch_take(op, punch_sel_r);
            if (punch_take(op, punch_sel_r)) begin
                punch_char <= op_data;
            end
        end
    end

    // ======================================================
    // Status byte
    // ======================================================
    // Busy and unavailable come from the selected unit only. The strobe
    // cycle counts as busy so that back-to-back writes see the punch busy.
    always_comb begin
        if (punch_sel_r) begin
            busy = !punch_ready || punch_strobe;
            unavail = !punch_power_ok || !punch_volts_ok ||
                      !punch_run || punch_chad_full;
        end else begin
            busy = !buf_full_r || !reader_run || !reader_power_ok;
            unavail = !reader_power_ok || !reader_run ||
                      feed_timeout_r;
        end
    end

    assign examine = overflow_r || stopped_r;
    always_comb begin
        status = status_pack(overflow_r, stopped_r, busy, examine, unavail,
                             punch_sel_r);
    end

    // ======================================================
    // Interrupts
    // ======================================================
    // Forcing the busy history high on a mode change makes a new unit that
    // is already free look like a busy-to-free edge in the next cycle,
    // which raises the mode-change interrupt.
    always_ff @(posedge clk) begin
        if (init) begin
            busy_prev_r <= 1'b1;
            unavail_prev_r <= 1'b0;
        end else begin
            busy_prev_r <= mode_change ? 1'b1 : busy;
            unavail_prev_r <= unavail;
        end
    end

    // A new event in the acknowledge cycle stays pending, so an edge is
    // never swallowed by an acknowledge meant for the previous one.
    // While disarmed nothing is queued at all.
    always_ff @(posedge clk) begin
        if (init || mode_change) begin
            pending_r <= 1'b0;
        end else if (irq_mode_r == TPRP_IRQ_DISARMED) begin
            pending_r <= 1'b0;
        end else if ((busy_prev_r && !busy) ||
                     (!unavail_prev_r && unavail)) begin
            pending_r <= 1'b1;
        end else if (op == TPRP_OP_ACK) begin
            pending_r <= 1'b0;
        end
    end

    assign irq_req = pending_r && (irq_mode_r == TPRP_IRQ_ENABLED);

    // Read data and the acknowledge address hold until the next transfer
    // that returns data, so the processor may sample them late.
    always_ff @(posedge clk) begin
        if (init) begin
            op_rdata <= 8'h00;
            ack_addr <= 8'h00;
        end else begin
            unique case (op)
                TPRP_OP_STATUS: op_rdata <= status;
                TPRP_OP_READ: op_rdata <= buf_r;
                TPRP_OP_ACK: begin
                    op_rdata <= status;
                    ack_addr <= DEV_ADDR;
                end
                default: op_rdata <= op_rdata;
            endcase
        end
    end
endmodule : tprp_ctrl

//--- tprp_ctrl_props.sv
// Port checker for the tape reader/punch controller.
// Assumes it is bound to tprp_ctrl and sees only its ports.
`timescale 1ns/100ps
module tprp_ctrl_props
    import tprp_pkg::*;
#(
    parameter logic [7:0] DEV_ADDR = 8'h13
) (
    input wire logic clk,
    input wire logic rst,
    input wire tprp_pkg::tprp_op_t op,
    input wire logic [7:0] op_data,
    input wire logic [7:0] op_rdata,
    input wire logic [7:0] ack_addr,
    input wire logic irq_req,
    input wire logic reader_power_ok,
    input wire logic reader_run,
    input wire logic punch_strobe,
    input wire logic [7:0] punch_char
);
    logic pm_r;
    logic [1:0] im_r;
    // Mirrors the selected unit and the interrupt mode.
    always_ff @(posedge clk) begin
        if (rst && reader_power_ok && reader_run) begin
            pm_r <= 1'b0;
            im_r <= 2'd0;
        end else if (op == TPRP_OP_COMMAND) begin
            if (^op_data[1:0]) begin
                pm_r <= op_data[1];
            end
            if (op_data[7:6] != 2'b00) begin
                im_r <= {op_data[6] & ~op_data[7], op_data[7] & ~op_data[6]};
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_stat;
        $past(op) == TPRP_OP_STATUS || $past(op) == TPRP_OP_ACK;
    endsequence
    sequence s_punched;
        punch_strobe && punch_char == $past(op_data);
    endsequence
    a_status_zeros: assert property (
        s_stat |-> op_rdata[6:5] == 2'b00 && !op_rdata[1])
        else $error("reserved status bit set");
    a_examine_or: assert property (
        s_stat |-> op_rdata[2] == (op_rdata[7] | op_rdata[4]))
        else $error("examine flag wrong");
    a_punch_quiet: assert property (
        s_stat ##0 $past(pm_r) |-> (op_rdata & 8'h94) == 8'h00)
        else $error("reader flags set in punch mode");
    a_ack_addr: assert property (
        op == TPRP_OP_ACK |=> ack_addr == DEV_ADDR)
        else $error("wrong acknowledge address");
    a_write_punch: assert property (
        op == TPRP_OP_WRITE && pm_r |=> s_punched)
        else $error("write not punched");
    a_write_refused: assert property (
        op == TPRP_OP_WRITE && !pm_r |=> !punch_strobe)
        else $error("write punched in reader mode");
    a_disarm_quiet: assert property (im_r == 2'd0 |-> !irq_req)
        else $error("interrupt while disarmed");
    a_disable_quiet: assert property (im_r == 2'd1 |-> !irq_req)
        else $error("interrupt while disabled");
endmodule : tprp_ctrl_props
bind tprp_ctrl tprp_ctrl_props #(.DEV_ADDR(DEV_ADDR)) tprp_ctrl_props_i (
    .clk, .rst, .op, .op_data, .op_rdata, .ack_addr, .irq_req,
    .reader_power_ok, .reader_run, .punch_strobe, .punch_char
);

//--- tprp_mech.sv
// Behavioural reader and punch mechanism facing the controller.
// Assumes gap sets the speed and no_tape hides all feed holes.
`timescale 1ns/100ps
module tprp_mech (
    input wire logic clk,
    input wire logic [7:0] gap,
    input wire logic no_tape,
    input wire logic reader_drive,
    input wire logic punch_strobe,
    output logic reader_char_strobe,
    output logic [7:0] reader_char,
    output logic reader_feed_hole,
    output logic punch_ready
);
    logic [7:0] cnt_r;
    logic [7:0] next_r;
    logic [7:0] pun_r;
    initial begin
        cnt_r = 8'h00;
        next_r = 8'ha0;
        pun_r = 8'h00;
        reader_char = 8'h00;
        reader_char_strobe = 1'b0;
        reader_feed_hole = 1'b0;
    end
    // Data lines toggle between characters so stale data never looks valid.
    always @(posedge clk) begin
        reader_char_strobe <= 1'b0;
        reader_feed_hole <= 1'b0;
        reader_char <= ~reader_char;
        cnt_r <= reader_drive ? cnt_r + 8'h01 : 8'h00;
        if (reader_drive && !no_tape && cnt_r >= gap) begin
            cnt_r <= 8'h00;
            reader_char_strobe <= 1'b1;
            reader_feed_hole <= 1'b1;
            reader_char <= next_r;
            next_r <= next_r + 8'h01;
        end
        if (punch_strobe) begin
            pun_r <= gap;
        end else if (pun_r != 8'h00) begin
            pun_r <= pun_r - 8'h01;
        end
    end
    assign punch_ready = pun_r == 8'h00 && !punch_strobe;
endmodule : tprp_mech

//--- tb.sv
// Self-checking bench for the tape reader/punch controller.
// Assumes the package, the controller and the mechanism model.
`timescale 1ns/100ps
module tb;
    import tprp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    tprp_op_t op = TPRP_OP_NONE;
    logic [7:0] op_data = 8'h00;
    logic [7:0] gap = 8'h08;
    logic [7:0] op_rdata, ack_addr, punch_char, reader_char;
    logic irq_req, reader_drive, punch_strobe, reader_char_strobe;
    logic reader_feed_hole, punch_ready, no_tape = 1'b0;
    logic reader_power_ok = 1'b1, reader_run = 1'b1, punch_run = 1'b1;
    logic punch_power_ok = 1'b1, punch_volts_ok = 1'b1;
    logic punch_chad_full = 1'b0;
    int miscompares = 0;
    int tests_run = 0;
    always #5 clk = ~clk;
    tprp_ctrl #(.FEED_TIMEOUT(20)) tprp_ctrl_i (.clk, .rst, .op, .op_data,
        .op_rdata, .ack_addr, .irq_req, .reader_power_ok, .reader_run,
        .reader_char_strobe, .reader_char, .reader_feed_hole, .reader_drive,
        .punch_power_ok, .punch_volts_ok, .punch_run, .punch_chad_full,
        .punch_ready, .punch_strobe, .punch_char);
    tprp_mech tprp_mech_i (.clk, .gap, .no_tape, .reader_drive,
        .punch_strobe, .reader_char_strobe, .reader_char,
        .reader_feed_hole, .punch_ready);
    // ====================
    // Report, check and transfer tasks
    task automatic final_report;
        $display("Compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string s, input logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic xfer(input tprp_op_t o, input logic [7:0] d);
        @(posedge clk);
        #1 op = o;
        op_data = d;
        @(posedge clk);
        #1 op = TPRP_OP_NONE;
    endtask : xfer
    task automatic stat(input logic [7:0] m, input logic [7:0] e);
        xfer(TPRP_OP_STATUS, 8'h00);
        chk("status", e, op_rdata & m);
    endtask : stat
    task automatic await_st(input logic [7:0] m, input logic [7:0] e);
        xfer(TPRP_OP_STATUS, 8'h00);
        for (int i = 0; i < 300 && (op_rdata & m) !== e; i++) begin
            xfer(TPRP_OP_STATUS, 8'h00);
        end
        chk("status wait", e, op_rdata & m);
        if ((op_rdata & m) !== e) final_report();
    endtask : await_st
    task automatic await_irq;
        for (int i = 0; i < 300 && irq_req !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("irq wait", 8'h01, {7'h00, irq_req});
        if (irq_req !== 1'b1) final_report();
    endtask : await_irq
    task automatic pulse_rst;
        @(posedge clk);
        #1 rst = 1'b1;
        @(posedge clk);
        #1 rst = 1'b0;
    endtask : pulse_rst
    // ====================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        stat(8'hff, 8'h1c);
        xfer(TPRP_OP_COMMAND, 8'hd9);
        xfer(TPRP_OP_READ, 8'h00);
        chk("drive", 8'h01, {7'h00, reader_drive});
        await_st(8'hff, 8'h14);
        chk("drive", 8'h00, {7'h00, reader_drive});
        xfer(TPRP_OP_READ, 8'h00);
        chk("char", 8'ha0, op_rdata);
        $display("Test step read done");
        xfer(TPRP_OP_COMMAND, 8'h59);
        await_irq();
        xfer(TPRP_OP_ACK, 8'h00);
        chk("ack addr", 8'h13, ack_addr);
        chk("ack status", 8'h14, op_rdata);
        chk("irq", 8'h00, {7'h00, irq_req});
        xfer(TPRP_OP_COMMAND, 8'h99);
        xfer(TPRP_OP_READ, 8'h00);
        chk("char", 8'ha1, op_rdata);
        await_st(8'h08, 8'h00);
        chk("irq", 8'h00, {7'h00, irq_req});
        xfer(TPRP_OP_COMMAND, 8'h59);
        chk("irq", 8'h01, {7'h00, irq_req});
        xfer(TPRP_OP_COMMAND, 8'hd9);
        chk("irq", 8'h00, {7'h00, irq_req});
        xfer(TPRP_OP_READ, 8'h00);
        await_st(8'h08, 8'h00);
        xfer(TPRP_OP_COMMAND, 8'h59);
        chk("irq", 8'h00, {7'h00, irq_req});
        $display("Test interrupts done");
        xfer(TPRP_OP_COMMAND, 8'h42);
        await_irq();
        stat(8'hff, 8'h00);
        xfer(TPRP_OP_ACK, 8'h00);
        xfer(TPRP_OP_WRITE, 8'h5a);
        chk("punch strobe", 8'h01, {7'h00, punch_strobe});
        chk("punch char", 8'h5a, punch_char);
        stat(8'h08, 8'h08);
        await_irq();
        xfer(TPRP_OP_ACK, 8'h00);
        punch_chad_full = 1'b1;
        await_irq();
        stat(8'h01, 8'h01);
        punch_chad_full = 1'b0;
        stat(8'h01, 8'h00);
        reader_run = 1'b0;
        pulse_rst();
        stat(8'h10, 8'h00);
        reader_run = 1'b1;
        pulse_rst();
        stat(8'hff, 8'h1c);
        $display("Test punch done");
        gap = 8'h02;
        xfer(TPRP_OP_COMMAND, 8'hd5);
        await_st(8'h94, 8'h84);
        xfer(TPRP_OP_COMMAND, 8'he0);
        await_st(8'h10, 8'h10);
        gap = 8'h40;
        xfer(TPRP_OP_COMMAND, 8'hd5);
        stat(8'h90, 8'h00);
        no_tape = 1'b1;
        await_st(8'h01, 8'h01);
        gap = 8'h08;
        no_tape = 1'b0;
        await_st(8'h01, 8'h00);
        reader_power_ok = 1'b0;
        stat(8'h09, 8'h09);
        $display("Test slew done");
        final_report();
    end
endmodule : tb
